// *** src/epfc_capture.sv ***
// Purpose: Position capture on marker and freeze events, Sin/commutation report
// Assumes: Live position arrives from feedback logic on the same clock
// Notes: Marker, freeze and commutation pins are asynchronous and synchronised
module epfc_capture
	import epfc_pkg::*;
#(
	parameter int FWD_CYCLES = FWD_PULSE_CYCLES
) (
	input wire logic clock,
	input wire logic rst_n,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Live position from feedback logic
	input wire logic pos_valid,
	input wire logic [15:0] pos_revolutions,
	input wire logic [15:0] pos_coarse,
	input wire logic [15:0] pos_fine,
	// Asynchronous event pins
	input wire logic marker_in,
	input wire logic freeze_24v_in,
	input wire logic freeze_485_in,
	input wire logic freeze_bus_in,
	output logic freeze_bus_out,
	// Sin sample and commutation inputs
	input wire logic adc_valid,
	input wire logic [9:0] adc_sin,
	input wire logic comms_present,
	input wire logic [3:0] commutation_segment,
	input wire logic commut_u_in,
	input wire logic commut_v_in,
	input wire logic commut_w_in
);
	localparam int FWD_W = $clog2(FWD_CYCLES + 1);

	// Refuse a forwarded pulse length of zero
	generate
		if (FWD_CYCLES < 1) begin : g_bad_fwd
			$error("FWD_CYCLES must be at least one");
		end
	endgenerate

	logic [15:0] live_rev_ff;
	logic [15:0] live_pos_ff;
	logic [15:0] live_fine_ff;
	logic [15:0] mark_rev_ff;
	logic [15:0] mark_pos_ff;
	logic [15:0] mark_fine_ff;
	logic [15:0] frz_rev_ff;
	logic [15:0] frz_pos_ff;
	logic [15:0] frz_fine_ff;
	logic [2:0] src_sel_ff;
	logic flag_ff;
	logic fwd_en_ff;
	logic invert_ff;
	logic [15:0] tx_sin_ff;
	logic [2:0] enc_mode_ff;
	logic ack_ff;
	logic [31:0] rdata_ff;
	logic [6:0] sync1_ff;
	logic [6:0] sync2_ff;
	logic marker_prev_ff;
	logic freeze_prev_ff;
	logic [FWD_W-1:0] fwd_cnt_ff;
	logic fwd_out_ff;

	logic bus_req;
	logic wr_en;
	logic wr_lo;
	logic wr_hi;
	logic marker_s;
	logic frz_24v_s;
	logic frz_485_s;
	logic frz_bus_s;
	logic u_s;
	logic v_s;
	logic w_s;
	logic freeze_level;
	logic freeze_edge;
	logic marker_edge;
	logic capture_freeze;
	logic commut_mode;
	logic [15:0] commut_value;
	logic [15:0] sin_value;
	logic [31:0] nxt_rdata;

	// Bus decode: answer one cycle after the request
	assign bus_req = wb_cyc_i & wb_stb_i & ~ack_ff;
	assign wr_en = bus_req & wb_we_i;
	assign wr_lo = wr_en & wb_sel_i[0];
	assign wr_hi = wr_en & wb_sel_i[1];

	// Two-stage synchronisers for the marker, freeze and U/V/W pins
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			sync1_ff <= 7'h00;
			sync2_ff <= 7'h00;
		end else begin
			sync1_ff <= {commut_w_in, commut_v_in, commut_u_in, freeze_bus_in,
				freeze_485_in, freeze_24v_in, marker_in};
			sync2_ff <= sync1_ff;
		end
	end

	assign marker_s = sync2_ff[0];
	assign frz_24v_s = sync2_ff[1];
	assign frz_485_s = sync2_ff[2];
	assign frz_bus_s = sync2_ff[3];
	assign u_s = sync2_ff[4];
	assign v_s = sync2_ff[5];
	assign w_s = sync2_ff[6];

	// Enabled sources combined into one freeze level
	assign freeze_level = (frz_24v_s & src_sel_ff[SRC_BIT_24V])
		| (frz_485_s & src_sel_ff[SRC_BIT_485])
		| (frz_bus_s & src_sel_ff[SRC_BIT_BUS]);

	// Edge polarity chosen by the invert bit
	assign freeze_edge = invert_ff ? (freeze_prev_ff & ~freeze_level)
		: (~freeze_prev_ff & freeze_level);
	assign capture_freeze = freeze_edge & ~flag_ff;
	assign marker_edge = marker_s & ~marker_prev_ff;

	// Previous levels for edge detection
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			marker_prev_ff <= 1'b0;
			freeze_prev_ff <= 1'b0;
		end else begin
			marker_prev_ff <= marker_s;
			freeze_prev_ff <= freeze_level;
		end
	end

	// Live non-marker position, untouched by events
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			live_rev_ff <= 16'h0000;
			live_pos_ff <= 16'h0000;
			live_fine_ff <= 16'h0000;
		end else if (pos_valid) begin
			live_rev_ff <= pos_revolutions;
			live_pos_ff <= pos_coarse;
			live_fine_ff <= pos_fine;
		end
	end

	// Marker capture
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			mark_rev_ff <= 16'h0000;
			mark_pos_ff <= 16'h0000;
			mark_fine_ff <= 16'h0000;
		end else if (marker_edge) begin
			mark_rev_ff <= live_rev_ff;
			mark_pos_ff <= live_pos_ff;
			mark_fine_ff <= live_fine_ff;
		end
	end

	// Freeze capture, held while the flag is set
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			frz_rev_ff <= 16'h0000;
			frz_pos_ff <= 16'h0000;
			frz_fine_ff <= 16'h0000;
		end else if (capture_freeze) begin
			frz_rev_ff <= live_rev_ff;
			frz_pos_ff <= live_pos_ff;
			frz_fine_ff <= live_fine_ff;
		end
	end

	// Freeze flag: set by capture, cleared only by software, set wins
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			flag_ff <= 1'b0;
		end else if (capture_freeze) begin
			flag_ff <= 1'b1;
		end else if (wr_lo && wb_adr_i == OFS_FLAG) begin
			flag_ff <= wb_dat_i[0];
		end
	end

	// Configuration registers
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			src_sel_ff <= RST_SRC_SEL;
			fwd_en_ff <= 1'b0;
			invert_ff <= 1'b0;
			enc_mode_ff <= RST_ENC_MODE;
		end else if (wr_lo) begin
			case (wb_adr_i)
				OFS_SRC_SEL: src_sel_ff <= wb_dat_i[2:0];
				OFS_FWD_EN: fwd_en_ff <= wb_dat_i[0];
				OFS_INVERT: invert_ff <= wb_dat_i[0];
				OFS_ENC_MODE: enc_mode_ff <= wb_dat_i[2:0];
				default: ;
			endcase
		end
	end

	// Forward any captured freeze, slot bus source included, to the slot bus as a stretched pulse
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			fwd_cnt_ff <= '0;
			fwd_out_ff <= 1'b0;
		end else if (capture_freeze && fwd_en_ff) begin
			fwd_cnt_ff <= FWD_W'(FWD_CYCLES - 1);
			fwd_out_ff <= 1'b1;
		end else if (fwd_cnt_ff != '0) begin
			fwd_cnt_ff <= fwd_cnt_ff - 1'b1;
		end else begin
			fwd_out_ff <= 1'b0;
		end
	end

	assign freeze_bus_out = fwd_out_ff;

	// Commutation status: 1000*segment + 100*U + 10*V + W
	assign commut_value = 16'(W_SEGMENT * {12'h000, commutation_segment})
		+ (u_s ? W_U : 16'h0000)
		+ (v_s ? W_V : 16'h0000)
		+ {15'h0000, w_s};
	assign commut_mode = (enc_mode_ff == MODE_QUAD_COMMUT) || (enc_mode_ff == MODE_FREQ_COMMUT)
		|| (enc_mode_ff == MODE_FWDREV_COMMUT);

	// Sin sample, MSB of the ADC at bit 14, sign extended into bit 15
	assign sin_value = {adc_sin[ADC_WIDTH-1], adc_sin, {ADC_SHIFT{1'b0}}};

	// Transmit / Sin / commutation register
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			tx_sin_ff <= RST_TX_SIN;
		end else if (commut_mode) begin
			tx_sin_ff <= commut_value;
		end else if (enc_mode_ff == MODE_ANALOG_SINE_COSINE_MODE && !comms_present && adc_valid) begin
			tx_sin_ff <= sin_value;
		end else if (wb_adr_i == OFS_TX_SIN && (wr_lo || wr_hi)) begin
			tx_sin_ff <= {wr_hi ? wb_dat_i[15:8] : tx_sin_ff[15:8],
				wr_lo ? wb_dat_i[7:0] : tx_sin_ff[7:0]};
		end
	end

	// Read multiplexer, unmapped addresses read zero
	always_comb begin
		nxt_rdata = 32'h0000_0000;
		case (wb_adr_i)
			OFS_LIVE_REV: nxt_rdata = {16'h0000, live_rev_ff};
			OFS_LIVE_POS: nxt_rdata = {16'h0000, live_pos_ff};
			OFS_LIVE_FINE: nxt_rdata = {16'h0000, live_fine_ff};
			OFS_MARK_REV: nxt_rdata = {16'h0000, mark_rev_ff};
			OFS_MARK_POS: nxt_rdata = {16'h0000, mark_pos_ff};
			OFS_MARK_FINE: nxt_rdata = {16'h0000, mark_fine_ff};
			OFS_FRZ_REV: nxt_rdata = {16'h0000, frz_rev_ff};
			OFS_FRZ_POS: nxt_rdata = {16'h0000, frz_pos_ff};
			OFS_FRZ_FINE: nxt_rdata = {16'h0000, frz_fine_ff};
			OFS_SRC_SEL: nxt_rdata = {29'h0000_0000, src_sel_ff};
			OFS_FLAG: nxt_rdata = {31'h0000_0000, flag_ff};
			OFS_FWD_EN: nxt_rdata = {31'h0000_0000, fwd_en_ff};
			OFS_INVERT: nxt_rdata = {31'h0000_0000, invert_ff};
			OFS_TX_SIN: nxt_rdata = {16'h0000, tx_sin_ff};
			OFS_ENC_MODE: nxt_rdata = {29'h0000_0000, enc_mode_ff};
			default: nxt_rdata = 32'h0000_0000;
		endcase
	end

	// Bus answer registers
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ack_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
		end else begin
			ack_ff <= bus_req;
			rdata_ff <= bus_req ? nxt_rdata : rdata_ff;
		end
	end

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rdata_ff;
endmodule : epfc_capture

// *** src/epfc_pkg.sv ***
// Purpose: Constants for the encoder position freeze capture block
// Assumes: 32-bit classic Wishbone, 50 MHz clock
// Notes: Each register holds one aligned word, narrow data in the low bits
// Summary of operation
// - Keep live non-marker position from the encoder
// - Marker activation captures live position into marker
// - Freeze event captures position, sets freeze flag
// - Flag never self-clears; user clears it
// - Flag set blocks further freeze captures
// - Freeze sources: 485, 24V and slot bus
// - Source select is enable mask 1,2,4
// - Source select resets to 24V only
// - Forward enable drives freeze to slot bus
// - Invert selects rising or falling freeze edge
// - Sine mode writes Sin sample when idle
// - ADC MSB at bit 14, steps of 32
// - Commutation modes load commutation status instead
// - Status equals 1000 seg+100U+10V+W
package epfc_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_LIVE_REV = 8'h00;
	localparam logic [7:0] OFS_LIVE_POS = 8'h04;
	localparam logic [7:0] OFS_LIVE_FINE = 8'h08;
	localparam logic [7:0] OFS_MARK_REV = 8'h0C;
	localparam logic [7:0] OFS_MARK_POS = 8'h10;
	localparam logic [7:0] OFS_MARK_FINE = 8'h14;
	localparam logic [7:0] OFS_FRZ_REV = 8'h18;
	localparam logic [7:0] OFS_FRZ_POS = 8'h1C;
	localparam logic [7:0] OFS_FRZ_FINE = 8'h20;
	localparam logic [7:0] OFS_SRC_SEL = 8'h24;
	localparam logic [7:0] OFS_FLAG = 8'h28;
	localparam logic [7:0] OFS_FWD_EN = 8'h2C;
	localparam logic [7:0] OFS_INVERT = 8'h30;
	localparam logic [7:0] OFS_TX_SIN = 8'h34;
	localparam logic [7:0] OFS_ENC_MODE = 8'h38;
	// Source mask bit positions
	localparam int SRC_BIT_24V = 0;
	localparam int SRC_BIT_485 = 1;
	localparam int SRC_BIT_BUS = 2;
	// Reset values
	localparam logic [2:0] RST_SRC_SEL = 3'h1;
	localparam logic [15:0] RST_TX_SIN = 16'h0000;
	localparam logic [2:0] RST_ENC_MODE = 3'h0;
	// Encoder modes
	localparam logic [2:0] MODE_QUAD_COMMUT = 3'h3;
	localparam logic [2:0] MODE_FREQ_COMMUT = 3'h4;
	localparam logic [2:0] MODE_FWDREV_COMMUT = 3'h5;
	localparam logic [2:0] MODE_ANALOG_SINE_COSINE_MODE = 3'h6;
	// Sin sample placement
	localparam int ADC_WIDTH = 10;
	localparam int ADC_SHIFT = 5;
	// Commutation weights
	localparam logic [15:0] W_SEGMENT = 16'h03E8;
	localparam logic [15:0] W_U = 16'h0064;
	localparam logic [15:0] W_V = 16'h000A;
	// Forwarded freeze pulse length
	localparam int CLOCK_HZ = 50000000;
	localparam int FWD_PULSE_NS = 1000;
	localparam int FWD_PULSE_CYCLES = (FWD_PULSE_NS * (CLOCK_HZ / 1000000) + 999) / 1000;
endpackage : epfc_pkg

// *** testbench/epfc_chk.sv ***
// Purpose: Bus and forward pulse checks
// Assumes: Bound to the capture block
// Notes: Forward enable shadowed from writes
module epfc_chk
	import epfc_pkg::*;
#(
	parameter int FWD_CYCLES = FWD_PULSE_CYCLES
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic freeze_bus_out
);
	logic req;
	logic fwd_ff;
	logic [7:0] cnt_ff;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// Request about to be taken
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	// Shadow of forward enable
	always_ff @(posedge clock) begin
		if (!rst_n)
			fwd_ff <= 1'b0;
		else if (req && wb_we_i && wb_sel_i[0] && wb_adr_i == OFS_FWD_EN)
			fwd_ff <= wb_dat_i[0];
	end
	// Cycles the forward line has been high
	always_ff @(posedge clock) begin
		cnt_ff <= freeze_bus_out ? cnt_ff + 8'h01 : 8'h00;
	end
	a_ack_next: assert property (req |=> wb_ack_o) else $error("ack late");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
	a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
	a_dat_hold: assert property (!(wb_cyc_i && wb_stb_i) |=> $stable(wb_dat_o)) else $error("data moved");
	a_unmapped_zero: assert property (req && !wb_we_i && wb_adr_i == 8'h3C |=> wb_dat_o == 32'h0)
		else $error("unmapped read");
	a_fwd_len: assert property (freeze_bus_out |-> cnt_ff < FWD_CYCLES) else $error("pulse long");
	a_fwd_full: assert property ($fell(freeze_bus_out) |-> cnt_ff == FWD_CYCLES) else $error("pulse short");
	a_fwd_quiet: assert property (!fwd_ff && !freeze_bus_out |=> !freeze_bus_out) else $error("forward off");
	c_fwd: cover property ($rose(freeze_bus_out));
	c_rd: cover property (req && !wb_we_i);
	c_wr: cover property (req && wb_we_i);
endmodule : epfc_chk
bind epfc_capture epfc_chk #(.FWD_CYCLES(FWD_CYCLES)) chk_u (.clock, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
	.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .freeze_bus_out);

// *** testbench/epfc_enc.sv ***
// Purpose: Encoder model giving live position
// Assumes: Advances only while move is high
// Notes: Holds still so captures are predictable
module epfc_enc (
	input wire logic clock,
	input wire logic move,
	input wire logic [15:0] step,
	output logic pos_valid,
	output logic [15:0] rev,
	output logic [15:0] crs,
	output logic [15:0] fine
);
	timeunit 1ns;
	timeprecision 1ns;
	initial {pos_valid, rev, crs, fine} = '0;
	// Step position, strobe each new value
	always @(posedge clock) begin
		pos_valid <= move;
		if (move) begin
			rev <= rev + 16'h0001;
			crs <= crs + step;
			fine <= fine - step;
		end
	end
endmodule : epfc_enc

// *** testbench/test_encoder_position_freeze_capture.sv ***
// Purpose: Self-checking bench for the capture block
// Assumes: Forward pulse shortened to 2 cycles
// Notes: Reads checked in order from a queue
module test_encoder_position_freeze_capture;
	import epfc_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, move = 0, av = 0, cp = 0, mk = 0;
	logic [2:0] frz = 0, uvw = 0;
	logic [3:0] sel = 0, seg = 0;
	logic [7:0] adr = 0;
	logic [9:0] adc = 0;
	logic [15:0] step = 0, cr = 0, cc = 0, cf = 0, sv = 0;
	logic [31:0] dat = 0, seed = 32'h17BB5DD9, dat_o;
	logic ack, fbo, pv;
	logic [15:0] rev, crs, fine;
	logic [31:0] expq[$];
	int failures = 0, compares = 0, pulses = 0;
	epfc_enc enc_u (.clock, .move, .step, .pos_valid(pv), .rev, .crs, .fine);
	epfc_capture #(.FWD_CYCLES(2)) dut_u (.clock, .rst_n, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .pos_valid(pv),
		.pos_revolutions(rev), .pos_coarse(crs), .pos_fine(fine), .marker_in(mk), .freeze_24v_in(frz[0]),
		.freeze_485_in(frz[1]), .freeze_bus_in(frz[2]), .freeze_bus_out(fbo), .adc_valid(av), .adc_sin(adc),
		.comms_present(cp), .commutation_segment(seg), .commut_u_in(uvw[2]), .commut_v_in(uvw[1]),
		.commut_w_in(uvw[0]));
	initial forever #10 clock = ~clock;
	// Count forwarded pulses
	always @(posedge fbo) pulses++;
	// Read results against oldest note
	always @(posedge clock) if (ack === 1'b1 && we === 1'b0) chk($sformatf("reg %h", adr), dat_o, expq.pop_front());
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			failures++;
			$display("Error %s exp %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic wt(input int n);
		repeat (n) @(posedge clock);
	endtask : wt
	// One bus cycle; on reads d is the expected word
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge clock);
		{cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, 4'h3};
		if (!w) expq.push_back(d);
		do @(posedge clock); while (ack !== 1'b1);
		{cyc, stb} <= 2'b00;
	endtask : bus
	// Move encoder one step, then hold
	task automatic mv();
		@(posedge clock);
		move <= 1'b1;
		step <= 16'(rnd());
		@(posedge clock);
		move <= 1'b0;
		wt(2);
	endtask : mv
	// Freeze on pin p, mask m, invert v, forward f
	task automatic frzt(input int p, input logic [2:0] m, input logic v, input logic f);
		logic e;
		int p0;
		// Falling edge of the OR needs every other enabled pin low
		e = m[p] && (!v || (m & ~(3'h1 << p)) == 3'h0);
		// Flag held set so reconfiguration edges are not trapped
		bus(OFS_FLAG, 1, 1);
		bus(OFS_SRC_SEL, 1, 32'(m));
		bus(OFS_INVERT, 1, 32'(v));
		bus(OFS_FWD_EN, 1, 32'(f));
		frz <= {3{v}};
		wt(4);
		bus(OFS_FLAG, 1, 0);
		mv();
		p0 = pulses;
		if (e) {cr, cc, cf} = {rev, crs, fine};
		frz[p] <= !v;
		wt(4);
		bus(OFS_FLAG, 0, 32'(e));
		frz[p] <= v;
		mv();
		frz[p] <= !v;
		wt(4);
		bus(OFS_FRZ_REV, 0, {16'h0, cr});
		bus(OFS_FRZ_POS, 0, {16'h0, cc});
		bus(OFS_FRZ_FINE, 0, {16'h0, cf});
		bus(OFS_FLAG, 0, 32'(e));
		bus(OFS_LIVE_POS, 0, {16'h0, crs});
		chk("pulses", 32'(pulses - p0), 32'(e & f));
	endtask : frzt
	task automatic wrap_up();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : wrap_up
	initial begin
		wt(10);
		rst_n <= 1'b1;
		bus(OFS_SRC_SEL, 0, 1);
		bus(OFS_FLAG, 0, 0);
		bus(OFS_TX_SIN, 0, 0);
		bus(8'h3C, 0, 0);
		$display("test reset done");
		for (int m = 0; m < 8; m++) frzt(int'(rnd() % 3), m[2:0], 1'(rnd()), 1'(rnd()));
		$display("test freeze done");
		mv();
		mk <= 1'b1;
		wt(4);
		bus(OFS_MARK_REV, 0, {16'h0, rev});
		bus(OFS_MARK_POS, 0, {16'h0, crs});
		bus(OFS_MARK_FINE, 0, {16'h0, fine});
		mk <= 1'b0;
		bus(OFS_FRZ_POS, 0, {16'h0, cc});
		$display("test marker done");
		for (int k = 3; k < 6; k++) begin
			seg <= 4'(rnd() % 10);
			uvw <= 3'(rnd());
			bus(OFS_ENC_MODE, 1, k);
			wt(4);
			bus(OFS_TX_SIN, 0, 32'(seg) * 1000 + uvw[2] * 100 + uvw[1] * 10 + uvw[0]);
		end
		$display("test commutation done");
		bus(OFS_ENC_MODE, 1, 6);
		for (int j = 0; j < 3; j++) begin
			cp <= j == 2;
			adc <= 10'(rnd());
			av <= 1'b1;
			@(posedge clock) av <= 1'b0;
			if (j < 2) sv = {adc[9], adc, 5'h0}; // Sign copied up
			wt(2);
			bus(OFS_TX_SIN, 0, {16'h0, sv});
		end
		$display("test sin done");
		wrap_up();
	end
	// Watchdog
	initial begin
		#400000;
		failures++;
		wrap_up();
	end
endmodule : test_encoder_position_freeze_capture
